// ==== verilog/psq_pkg.sv ====
// Constants shared by the PHY sleep and quality configuration register block
package psq_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;

  // Management frame layout
  localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
  localparam logic [5:0]  HDR_BITS        = 6'h0d;
  localparam logic [5:0]  DATA_BITS       = 6'h10;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;

  // Register offsets
  localparam logic [4:0]  REG_POWER_WAKE  = 5'h12;
  localparam logic [4:0]  REG_ADDR_QUAL   = 5'h13;

  // power_wake_config fields
  localparam int          PW_MASTER       = 15;
  localparam int          PW_LOC_FWD      = 14;
  localparam int          PW_REM_REACT    = 11;
  localparam int          PW_LOC_REACT    = 10;
  localparam int          PW_MII_MODE_LO  = 8;
  localparam int          PW_MII_DRV      = 7;
  localparam int          PW_SLEEP_CONF   = 6;
  localparam int          PW_LPC_WUR_DIS  = 5;
  localparam int          PW_SLEEP_ACK    = 4;
  localparam int          PW_REM_FWD      = 2;
  localparam int          PW_AUTO_PWD     = 1;
  localparam int          PW_AUTO_SLEEP   = 0;
  localparam logic [15:0] PW_RESET        = 16'h4c05;
  localparam logic [15:0] PW_WR_MASK      = 16'hcff7;

  // address_quality_config fields (station address sits above these)
  localparam int          AQ_AVG_LO       = 9;
  localparam int          AQ_WARN_LO      = 6;
  localparam int          AQ_FAIL_LO      = 3;
  localparam int          AQ_JUMBO        = 2;
  localparam int          AQ_SLEEP_TO_LO  = 0;
  localparam logic [10:0] AQ_RESET        = 11'h245;
  localparam logic [8:0]  AVG_BASE_SYMS   = 9'h020;
  localparam logic [14:0] PKT_MAX_SMALL   = 15'h1000;
  localparam logic [14:0] PKT_MAX_JUMBO   = 15'h4000;

  // Sleep acknowledge timeouts and wake detection activation time
  localparam int          TMR_W           = 17;
  localparam int unsigned ACK_TO0_US      = 200;
  localparam int unsigned ACK_TO1_US      = 500;
  localparam int unsigned ACK_TO2_US      = 2000;
  localparam int unsigned ACK_TO3_US      = 8000;
  localparam int unsigned ACK_TO0_CYC     = ACK_TO0_US * CYC_PER_US;
  localparam int unsigned ACK_TO1_CYC     = ACK_TO1_US * CYC_PER_US;
  localparam int unsigned ACK_TO2_CYC     = ACK_TO2_US * CYC_PER_US;
  localparam int unsigned ACK_TO3_CYC     = ACK_TO3_US * CYC_PER_US;
  localparam int unsigned WAKE_DET_US     = 50;
  localparam int unsigned WAKE_DET_CYC    = WAKE_DET_US * CYC_PER_US;

  typedef enum logic [2:0] {
    PSQ_PRE,
    PSQ_HDR,
    PSQ_TA,
    PSQ_DATA
  } psq_state_e;

endpackage

// ==== verilog/psq_sync2.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module psq_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk_i)
  begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// ==== verilog/psq_timer.sv ====
// Loadable down counter with one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module psq_timer
  import psq_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             start_i,
  input  wire logic             run_i,
  input  wire logic [TMR_W-1:0] load_i,
  output logic                  done_o,
  output logic                  busy_o
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (start_i)
    begin
      cnt_d = load_i;
    end
    else if (!run_i)
    begin
      // Dropping run cancels a count in progress
      cnt_d = '0;
    end
    else if (cnt_q != '0)
    begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == TMR_W'(1));
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign busy_o = (cnt_q != '0);

endmodule
`default_nettype wire

// ==== verilog/psq_config_regs.sv ====
// Sleep, wake and signal quality configuration registers behind the management port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - With sleep acknowledge off the ack timer stays idle and traffic returns sleep request to normal.
// - With sleep acknowledge on the ack timer runs and traffic never returns sleep request to normal.
// - Bit 2 of power_wake_config decides whether a detected remote wake-up is forwarded.
// - Bit 0 of power_wake_config, reset 1, enables moving to sleep request on a low-power code.
// - Local wake-ups are ignored during the activation time after local wake react is set.
// - Bits 15:11 of address_quality_config read the station address 00, two strap bits, 0.
// - Bits 10:9 pick 32, 64, 128 or 256 symbols of quality averaging, default 64.
// - Bits 8:6 hold the warning threshold, 000 none and 001 to 111 classes A to G, default 001.
// - Bits 5:3 hold the fail threshold, 000 none and default, 001 to 111 classes A to G.
// - Bit 2 of address_quality_config allows 16 kB packets when 1, default, else 4 kB.
// - A quality warning event latches when quality drops below the warning class with link up.
module psq_config_regs
  import psq_pkg::*;
#(
  parameter int unsigned ACK_CYC_0    = ACK_TO0_CYC,
  parameter int unsigned ACK_CYC_1    = ACK_TO1_CYC,
  parameter int unsigned ACK_CYC_2    = ACK_TO2_CYC,
  parameter int unsigned ACK_CYC_3    = ACK_TO3_CYC,
  parameter int unsigned WAKE_DET_CNT = WAKE_DET_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic        strap_master_i,
  input  wire logic [1:0]  strap_mii_mode_i,
  input  wire logic [1:0]  strap_addr_i,
  input  wire logic        local_wake_pin_i,
  input  wire logic        remote_wake_det_i,
  input  wire logic        low_power_sleep_code_group_i,
  input  wire logic        data_traffic_i,
  input  wire logic        in_normal_i,
  input  wire logic        in_sleep_req_i,
  input  wire logic [2:0]  signal_quality_indicator_i,
  input  wire logic        link_up_i,
  input  wire logic        quality_warn_clr_i,
  output logic [4:0]       station_address_o,
  output logic             master_o,
  output logic [1:0]       mii_mode_o,
  output logic             mii_drv_reduced_o,
  output logic             sleep_confirm_o,
  output logic             lpc_wur_dis_o,
  output logic             auto_pwd_en_o,
  output logic             sleep_ack_en_o,
  output logic             remote_wake_forward_en_o,
  output logic             local_wake_forward_en_o,
  output logic             remote_wake_react_en_o,
  output logic             local_wake_react_en_o,
  output logic             auto_sleep_on_lowpower_code_o,
  output logic [1:0]       sleep_req_timeout_sel_o,
  output logic             goto_sleep_req_o,
  output logic             goto_normal_o,
  output logic             ack_timeout_o,
  output logic             remote_wake_fwd_o,
  output logic             local_wake_o,
  output logic [8:0]       quality_average_len_o,
  output logic [2:0]       quality_warn_threshold_o,
  output logic [2:0]       quality_fail_threshold_o,
  output logic             quality_warn_event_o,
  output logic             quality_fail_o,
  output logic             jumbo_en_o,
  output logic [14:0]      max_packet_bytes_o
);

  function automatic logic [8:0] avg_symbols(input logic [1:0] sel);
    avg_symbols = AVG_BASE_SYMS << sel;
  endfunction

  function automatic logic below_class(input logic [2:0] sqv, input logic [2:0] thr);
    // Class 000 means no threshold, so nothing ever falls below it
    below_class = (thr != 3'h0) && (sqv < thr);
  endfunction

  function automatic logic [TMR_W-1:0] ack_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0:    ack_cycles = TMR_W'(ACK_CYC_0);
      2'h1:    ack_cycles = TMR_W'(ACK_CYC_1);
      2'h2:    ack_cycles = TMR_W'(ACK_CYC_2);
      2'h3:    ack_cycles = TMR_W'(ACK_CYC_3);
    endcase
  endfunction

  // Pin synchronisation
  logic [7:0]  pins_s;
  logic        mdc_s;
  logic        mdio_s;
  logic        lw_s;

  psq_sync2 #(
    .W (8)
  ) u_sync (
    .mclk_i  (mclk_i),
    .async_i ({strap_addr_i, strap_mii_mode_i, strap_master_i, local_wake_pin_i, mdio_i, mdc_i}),
    .sync_o  (pins_s)
  );

  assign mdc_s  = pins_s[0];
  assign mdio_s = pins_s[1];
  assign lw_s   = pins_s[2];

  // Serial engine and register state
  psq_state_e  st_q;
  psq_state_e  st_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic        rd_q;
  logic        rd_d;
  logic        sel_q;
  logic        sel_d;
  logic        oe_q;
  logic        oe_d;
  logic        mo_q;
  logic        mo_d;
  logic        mdc_prev_q;
  logic [15:0] cfg1_q;
  logic [15:0] cfg1_d;
  logic [10:0] cfg2_q;
  logic [10:0] cfg2_d;
  logic [4:0]  station_q;
  logic [15:0] cfg1_rst;
  logic        mdc_rise;
  logic [12:0] hdr;
  logic [15:0] wdata;
  logic [15:0] rval;
  logic        hit;

  assign mdc_rise = mdc_s & ~mdc_prev_q;
  assign hdr      = {sh_q[11:0], mdio_s};
  assign wdata    = {sh_q[14:0], mdio_s};

  always_comb
  begin
    cfg1_rst                                 = PW_RESET;
    cfg1_rst[PW_MASTER]                      = pins_s[3];
    cfg1_rst[PW_MII_MODE_LO+1:PW_MII_MODE_LO] = pins_s[5:4];
  end

  // Header: start bit, opcode, address, register
  assign hit = hdr[12] && (hdr[9:5] == station_q)
               && ((hdr[11:10] == OP_READ) || (hdr[11:10] == OP_WRITE))
               && ((hdr[4:0] == REG_POWER_WAKE) || (hdr[4:0] == REG_ADDR_QUAL));

  assign rval = sel_q ? {station_q, cfg2_q} : cfg1_q;

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    rd_d   = rd_q;
    sel_d  = sel_q;
    oe_d   = oe_q;
    mo_d   = mo_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    if (mdc_rise)
    begin
      unique case (st_q)
        PSQ_PRE:
        begin
          if (mdio_s)
          begin
            if (cnt_q < PREAMBLE_LEN)
              cnt_d = cnt_q + 6'h01;
          end
          else if (cnt_q == PREAMBLE_LEN)
          begin
            st_d  = PSQ_HDR;
            cnt_d = 6'h00;
          end
          else
          begin
            cnt_d = 6'h00;
          end
        end
        PSQ_HDR:
        begin
          sh_d  = {sh_q[14:0], mdio_s};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == HDR_BITS - 6'h01)
          begin
            cnt_d = 6'h00;
            rd_d  = (hdr[11:10] == OP_READ);
            sel_d = (hdr[4:0] == REG_ADDR_QUAL);
            // Frames for other addresses are left to whoever owns them
            st_d  = hit ? PSQ_TA : PSQ_PRE;
          end
        end
        PSQ_TA:
        begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00)
          begin
            oe_d = rd_q;
            mo_d = 1'b0;
          end
          else
          begin
            st_d  = PSQ_DATA;
            cnt_d = 6'h00;
            mo_d  = rval[15];
            sh_d  = {rval[14:0], 1'b0};
          end
        end
        PSQ_DATA:
        begin
          cnt_d = cnt_q + 6'h01;
          if (rd_q)
          begin
            mo_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end
          else
          begin
            sh_d = wdata;
          end
          if (cnt_q == DATA_BITS - 6'h01)
          begin
            st_d  = PSQ_PRE;
            cnt_d = 6'h00;
            oe_d  = 1'b0;
            mo_d  = 1'b0;
            if (!rd_q && !sel_q)
              cfg1_d = (cfg1_q & ~PW_WR_MASK) | (wdata & PW_WR_MASK);
            if (!rd_q && sel_q)
              cfg2_d = wdata[10:0];
          end
        end
        default:
        begin
          st_d  = PSQ_PRE;
          cnt_d = 6'h00;
          oe_d  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q       <= PSQ_PRE;
      cnt_q      <= 6'h00;
      sh_q       <= 16'h0000;
      rd_q       <= 1'b0;
      sel_q      <= 1'b0;
      oe_q       <= 1'b0;
      mo_q       <= 1'b0;
      mdc_prev_q <= 1'b0;
      // Straps are caught while reset is held and frozen after release
      cfg1_q     <= cfg1_rst;
      cfg2_q     <= AQ_RESET;
      station_q  <= {2'b00, pins_s[7:6], 1'b0};
    end
    else
    begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      rd_q       <= rd_d;
      sel_q      <= sel_d;
      oe_q       <= oe_d;
      mo_q       <= mo_d;
      mdc_prev_q <= mdc_s;
      cfg1_q     <= cfg1_d;
      cfg2_q     <= cfg2_d;
    end
  end

  assign mdio_o    = mo_q;
  assign mdio_oe_o = oe_q;

  // Configuration decode
  logic ack_en;
  logic react_loc;

  assign ack_en    = cfg1_q[PW_SLEEP_ACK];
  assign react_loc = cfg1_q[PW_LOC_REACT];

  assign station_address_o             = station_q;
  assign master_o                      = cfg1_q[PW_MASTER];
  assign mii_mode_o                    = cfg1_q[PW_MII_MODE_LO+1:PW_MII_MODE_LO];
  assign mii_drv_reduced_o             = cfg1_q[PW_MII_DRV];
  assign sleep_confirm_o               = cfg1_q[PW_SLEEP_CONF];
  assign lpc_wur_dis_o                 = cfg1_q[PW_LPC_WUR_DIS];
  assign auto_pwd_en_o                 = cfg1_q[PW_AUTO_PWD];
  assign sleep_ack_en_o                = ack_en;
  assign remote_wake_forward_en_o      = cfg1_q[PW_REM_FWD];
  assign local_wake_forward_en_o       = cfg1_q[PW_LOC_FWD];
  assign remote_wake_react_en_o        = cfg1_q[PW_REM_REACT];
  assign local_wake_react_en_o         = react_loc;
  assign auto_sleep_on_lowpower_code_o = cfg1_q[PW_AUTO_SLEEP];
  assign sleep_req_timeout_sel_o       = cfg2_q[AQ_SLEEP_TO_LO+1:AQ_SLEEP_TO_LO];
  assign quality_average_len_o         = avg_symbols(cfg2_q[AQ_AVG_LO+1:AQ_AVG_LO]);
  assign quality_warn_threshold_o      = cfg2_q[AQ_WARN_LO+2:AQ_WARN_LO];
  assign quality_fail_threshold_o      = cfg2_q[AQ_FAIL_LO+2:AQ_FAIL_LO];
  assign jumbo_en_o                    = cfg2_q[AQ_JUMBO];
  assign max_packet_bytes_o = cfg2_q[AQ_JUMBO] ? PKT_MAX_JUMBO : PKT_MAX_SMALL;

  // Timers
  logic sleep_prev_q;
  logic react_prev_q;
  logic wake_busy;

  psq_timer u_ack_tmr (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (ack_en & in_sleep_req_i & ~sleep_prev_q),
    .run_i     (ack_en & in_sleep_req_i),
    .load_i    (ack_cycles(sleep_req_timeout_sel_o)),
    .done_o    (ack_timeout_o),
    .busy_o    ()
  );

  psq_timer u_wake_tmr (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (react_loc & ~react_prev_q),
    .run_i     (react_loc),
    .load_i    (TMR_W'(WAKE_DET_CNT)),
    .done_o    (),
    .busy_o    (wake_busy)
  );

  // Event outputs
  logic lw_prev_q;
  logic goto_sleep_q;
  logic goto_sleep_d;
  logic goto_norm_q;
  logic goto_norm_d;
  logic rem_fwd_q;
  logic rem_fwd_d;
  logic loc_wake_q;
  logic loc_wake_d;
  logic warn_q;
  logic warn_d;
  logic fail_q;
  logic fail_d;

  always_comb
  begin
    goto_sleep_d = in_normal_i & low_power_sleep_code_group_i & cfg1_q[PW_AUTO_SLEEP];
    goto_norm_d  = in_sleep_req_i & data_traffic_i & ~ack_en;
    rem_fwd_d    = remote_wake_det_i & cfg1_q[PW_REM_FWD];
    // Until the detector has settled an edge may be noise, so it is dropped
    loc_wake_d   = lw_s & ~lw_prev_q & react_loc & ~wake_busy;
    // Set wins over a simultaneous clear
    warn_d       = (link_up_i & below_class(signal_quality_indicator_i,
                                            quality_warn_threshold_o))
                   | (warn_q & ~quality_warn_clr_i);
    fail_d       = link_up_i & below_class(signal_quality_indicator_i,
                                           quality_fail_threshold_o);
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sleep_prev_q <= 1'b0;
      react_prev_q <= 1'b0;
      lw_prev_q    <= 1'b0;
      goto_sleep_q <= 1'b0;
      goto_norm_q  <= 1'b0;
      rem_fwd_q    <= 1'b0;
      loc_wake_q   <= 1'b0;
      warn_q       <= 1'b0;
      fail_q       <= 1'b0;
    end
    else
    begin
      sleep_prev_q <= in_sleep_req_i;
      react_prev_q <= react_loc;
      lw_prev_q    <= lw_s;
      goto_sleep_q <= goto_sleep_d;
      goto_norm_q  <= goto_norm_d;
      rem_fwd_q    <= rem_fwd_d;
      loc_wake_q   <= loc_wake_d;
      warn_q       <= warn_d;
      fail_q       <= fail_d;
    end
  end

  assign goto_sleep_req_o     = goto_sleep_q;
  assign goto_normal_o        = goto_norm_q;
  assign remote_wake_fwd_o    = rem_fwd_q;
  assign local_wake_o         = loc_wake_q;
  assign quality_warn_event_o = warn_q;
  assign quality_fail_o       = fail_q;

endmodule
`default_nettype wire

// ==== dv/psq_mdio_host.sv ====
// Management host model that clocks read and write frames into the block
`timescale 1ns/1ps
`default_nettype none
module psq_mdio_host
  import psq_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  initial
  begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // MDC stands low between frames; half sets the speed of each phase
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, input int half, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge mclk_i);
      mdc_o     <= 1'b0;
      mdio_oe_o <= (i < 46) || (op == OP_WRITE);
      mdio_o    <= bits[63-i];
      repeat (half) @(posedge mclk_i);
      // Sample late in the low phase, where the block's bit stands settled
      if (i >= 48)
        rd[63-i] = mdio_i;
      mdc_o <= 1'b1;
      repeat (half - 1) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    mdc_o     <= 1'b0;
    mdio_oe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/psq_config_regs_monitor.sv ====
// Port-level assertions for the sleep and quality configuration block
`timescale 1ns/1ps
`default_nettype none
module psq_config_regs_monitor
  import psq_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        low_power_sleep_code_group_i,
  input wire logic        data_traffic_i,
  input wire logic        in_normal_i,
  input wire logic        in_sleep_req_i,
  input wire logic        remote_wake_det_i,
  input wire logic [2:0]  signal_quality_indicator_i,
  input wire logic        link_up_i,
  input wire logic        quality_warn_clr_i,
  input wire logic [4:0]  station_address_o,
  input wire logic        sleep_ack_en_o,
  input wire logic        remote_wake_forward_en_o,
  input wire logic        auto_sleep_on_lowpower_code_o,
  input wire logic        goto_sleep_req_o,
  input wire logic        goto_normal_o,
  input wire logic        ack_timeout_o,
  input wire logic        remote_wake_fwd_o,
  input wire logic [8:0]  quality_average_len_o,
  input wire logic [2:0]  quality_warn_threshold_o,
  input wire logic        quality_warn_event_o,
  input wire logic        jumbo_en_o,
  input wire logic [14:0] max_packet_bytes_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  AST_TRAFFIC_WAKES: assert property (!sleep_ack_en_o && in_sleep_req_i && data_traffic_i
    |=> goto_normal_o) else $error("traffic did not return to normal");
  // Three quiet cycles let a timer that was running settle
  AST_ACK_TIMER_OFF: assert property (!sleep_ack_en_o [*3] |-> !ack_timeout_o)
    else $error("ack timeout with acknowledge off");
  AST_ACK_HOLDS: assert property (sleep_ack_en_o && in_sleep_req_i |=> !goto_normal_o)
    else $error("left sleep request with acknowledge on");
  AST_REMOTE_FWD: assert property (remote_wake_det_i
    |=> remote_wake_fwd_o == $past(remote_wake_forward_en_o)) else $error("remote forward wrong");
  AST_LPC_SLEEP: assert property (in_normal_i && low_power_sleep_code_group_i
    |=> goto_sleep_req_o == $past(auto_sleep_on_lowpower_code_o)) else $error("sleep entry wrong");
  AST_STATION_FIXED: assert property (station_address_o[4:3] == 2'h0
    && !station_address_o[0] && ($past(sys_rst_i) || $stable(station_address_o)))
    else $error("station address bad");
  AST_AVG_LEN: assert property ($onehot(quality_average_len_o)
    && quality_average_len_o >= AVG_BASE_SYMS) else $error("averaging length bad");
  AST_PKT_LIMIT: assert property ($stable(jumbo_en_o)
    |-> max_packet_bytes_o == (jumbo_en_o ? PKT_MAX_JUMBO : PKT_MAX_SMALL))
    else $error("packet limit bad");
  AST_WARN_LATCH: assert property (link_up_i && quality_warn_threshold_o != 3'h0
    && signal_quality_indicator_i < quality_warn_threshold_o |-> ##[1:2] quality_warn_event_o)
    else $error("quality warning not latched");
  AST_WARN_STICKY: assert property (quality_warn_event_o && !quality_warn_clr_i
    |=> quality_warn_event_o) else $error("quality warning lost");

  COV_NORMAL: cover property (goto_normal_o);
  COV_ACK_TO: cover property (ack_timeout_o);
  COV_WARN: cover property ($rose(quality_warn_event_o));
endmodule

bind psq_config_regs psq_config_regs_monitor u_mon (.mclk_i, .sys_rst_i,
  .low_power_sleep_code_group_i, .data_traffic_i, .in_normal_i, .in_sleep_req_i,
  .remote_wake_det_i, .signal_quality_indicator_i, .link_up_i, .quality_warn_clr_i,
  .station_address_o, .sleep_ack_en_o, .remote_wake_forward_en_o,
  .auto_sleep_on_lowpower_code_o, .goto_sleep_req_o, .goto_normal_o, .ack_timeout_o,
  .remote_wake_fwd_o, .quality_average_len_o, .quality_warn_threshold_o,
  .quality_warn_event_o, .jumbo_en_o, .max_packet_bytes_o);
`default_nettype wire

// ==== dv/test_phy_sleep_sqi_config_regs.sv ====
// Self-checking bench for the sleep and quality configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_phy_sleep_sqi_config_regs
  import psq_pkg::*;
;
  localparam int AK1 = 30;
  logic        mclk, rst, mdc, md_h, md_hoe, md_d, md_doe, md_w, lw, lnk, wclr, s_m;
  logic [1:0]  s_mii, s_ad;
  logic [4:0]  ev_v, sta;
  logic [2:0]  sqv;
  logic [15:0] rd, got_v, d;
  logic [15:0] exp_q[$];
  logic [8:0]  avg;
  logic [2:0]  wth, fth;
  logic [14:0] mpk;
  logic        g_s, g_n, ack_to, rfw, lwo, qwe, qfo;
  int          bad_count, checks_done, half, n, q;
  int          seed = 32'hc4a60807;
  event        got_ev;

  // Pull-up holds the line high whenever nobody drives it
  assign md_w = md_doe ? md_d : (md_hoe ? md_h : 1'b1);

  psq_mdio_host u_host (.mclk_i(mclk), .mdio_i(md_w), .mdc_o(mdc), .mdio_o(md_h),
    .mdio_oe_o(md_hoe));

  psq_config_regs #(.ACK_CYC_0(20), .ACK_CYC_1(50), .ACK_CYC_2(40), .ACK_CYC_3(AK1),
    .WAKE_DET_CNT(40)) u_dut (.mclk_i(mclk), .sys_rst_i(rst), .mdc_i(mdc), .mdio_i(md_w),
    .mdio_o(md_d), .mdio_oe_o(md_doe), .strap_master_i(s_m), .strap_mii_mode_i(s_mii),
    .strap_addr_i(s_ad), .local_wake_pin_i(lw), .remote_wake_det_i(ev_v[0]),
    .low_power_sleep_code_group_i(ev_v[3]), .data_traffic_i(ev_v[1]), .in_normal_i(ev_v[4]),
    .in_sleep_req_i(ev_v[2]), .signal_quality_indicator_i(sqv), .link_up_i(lnk),
    .quality_warn_clr_i(wclr), .station_address_o(), .master_o(), .mii_mode_o(),
    .mii_drv_reduced_o(), .sleep_confirm_o(), .lpc_wur_dis_o(), .auto_pwd_en_o(),
    .sleep_ack_en_o(), .remote_wake_forward_en_o(), .local_wake_forward_en_o(),
    .remote_wake_react_en_o(), .local_wake_react_en_o(), .auto_sleep_on_lowpower_code_o(),
    .sleep_req_timeout_sel_o(), .goto_sleep_req_o(g_s), .goto_normal_o(g_n),
    .ack_timeout_o(ack_to), .remote_wake_fwd_o(rfw), .local_wake_o(lwo),
    .quality_average_len_o(avg), .quality_warn_threshold_o(wth),
    .quality_fail_threshold_o(fth), .quality_warn_event_o(qwe), .quality_fail_o(qfo),
    .jumbo_en_o(), .max_packet_bytes_o(mpk));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    exp_q.push_back(e);
    got_v = g;
    ->got_ev;
    @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
    u_host.xfer(OP_WRITE, sta, ra, v, half, rd);
  endtask

  task automatic chk_rd(input logic [4:0] ra, input logic [15:0] e);
    u_host.xfer(OP_READ, sta, ra, 16'h0, half, rd);
    chk(rd, e);
  endtask

  task automatic ev(input logic [4:0] v);
    @(posedge mclk);
    ev_v <= v;
    @(posedge mclk);
    ev_v <= 5'h0;
    @(posedge mclk);
    rd = 16'({g_s, g_n, rfw});
  endtask

  task automatic ack_run();
    n = 0;
    @(posedge mclk);
    ev_v <= 5'h04;
    for (int i = 1; i <= 60; i++)
    begin
      @(posedge mclk);
      if (ack_to === 1'b1 && n == 0)
        n = i;
    end
    ev_v <= 5'h0;
  endtask

  task automatic wake();
    n = 0;
    @(posedge mclk);
    lw <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      if (i == 4)
        lw <= 1'b0;
      if (lwo === 1'b1)
        n++;
    end
  endtask

  // Result checker: oldest note against each observed value
  initial
  forever
  begin
    @(got_ev);
    checks_done++;
    if (exp_q.size() == 0 || got_v !== exp_q[0])
    begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, got_v, exp_q[0]);
    end
    if (exp_q.size() != 0)
      void'(exp_q.pop_front());
  end

  initial
  begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    ev_v = 5'h0;
    lw = 1'b0;
    lnk = 1'b0;
    wclr = 1'b0;
    sqv = 3'h7;
    half = 5;
    {s_m, s_mii, s_ad} = 5'($random(seed));
    sta = {2'b00, s_ad, 1'b0};
    // Straps need the full sync depth while reset is held
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    chk_rd(REG_POWER_WAKE, (PW_RESET & 16'h7cff) | {s_m, 5'h0, s_mii, 8'h0});
    chk_rd(REG_ADDR_QUAL, {sta, AQ_RESET});
    chk(16'(avg), 16'h0040);
    chk(16'(mpk), 16'(PKT_MAX_JUMBO));
    $display("test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      half = 5 + 2 * i;
      d = (i == 2) ? 16'hffff : 16'($random(seed));
      wr_reg(REG_POWER_WAKE, d);
      chk_rd(REG_POWER_WAKE, d & PW_WR_MASK);
    end
    half = 5;
    $display("test power wake access done");
    for (int i = 0; i < 8; i++)
    begin
      d = {5'h1f, 2'(i), 3'(i), 3'(7 - i), 1'(i), 2'(i)};
      wr_reg(REG_ADDR_QUAL, d);
      chk_rd(REG_ADDR_QUAL, {sta, d[10:0]});
      chk(16'(avg), 16'(AVG_BASE_SYMS) << i[1:0]);
      chk(16'({wth, fth}), 16'({3'(i), 3'(7 - i)}));
      chk(16'(mpk), 16'(i[0] ? PKT_MAX_JUMBO : PKT_MAX_SMALL));
    end
    u_host.xfer(OP_WRITE, sta ^ 5'h04, REG_ADDR_QUAL, 16'h0, half, rd);
    chk_rd(REG_ADDR_QUAL, {sta, d[10:0]});
    chk_rd(5'h14, 16'hffff);
    $display("test quality fields done");
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(REG_POWER_WAKE, c ? 16'h0010 : 16'h0005);
      for (int i = 0; i < 3; i++)
      begin
        ev(5'(i == 0 ? 5'h18 : (i == 1 ? 5'h06 : 5'h01)));
        chk(rd, c ? 16'h0 : 16'(3'b100 >> i));
      end
      ack_run();
      chk(c ? 16'(n >= AK1 + 1 && n <= AK1 + 4) : 16'(n), 16'(c));
    end
    $display("test sleep events done");
    wr_reg(REG_POWER_WAKE, 16'h0000);
    wr_reg(REG_POWER_WAKE, 16'h0400);
    wake();
    chk(16'(n), 16'h0);
    repeat (60) @(posedge mclk);
    wake();
    chk(16'(n), 16'h1);
    $display("test local wake done");
    wr_reg(REG_ADDR_QUAL, {5'h0, 2'b01, 3'h3, 3'h2, 1'b1, 2'b01});
    for (int i = 0; i < 6; i++)
    begin
      q = (i == 0) ? 9 : $random(seed);
      @(posedge mclk);
      wclr <= 1'b1;
      @(posedge mclk);
      wclr <= 1'b0;
      sqv <= 3'(q);
      lnk <= q[3];
      repeat (3) @(posedge mclk);
      sqv <= 3'h7;
      chk(16'({qwe, qfo}), 16'({q[3] && q[2:0] < 3, q[3] && q[2:0] < 2}));
      repeat (3) @(posedge mclk);
      chk(16'(qwe), 16'(q[3] && q[2:0] < 3));
    end
    $display("test quality warning done");
    final_report();
  end
endmodule
`default_nettype wire
